// file: rtl/swit_top.sv
// Subclock watchdog and interval timer with APB registers.
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module swit_top #(
	parameter int SUB_DIV = swit_pkg::SUB_DIV
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [swit_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic overflow_irq,
	output logic nmi,
	output logic sys_reset_req,
	output logic [15:0] irq_vector,
	output logic [3:0] irq_priority
);
	typedef struct packed {
		logic run;
		logic runaway;
		logic action;
		logic [2:0] code;
		logic [1:0] stat;
		logic [1:0] mask;
		logic restart;
		logic irq;
		logic nmi;
		logic wrst;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic [15:0] vec;
		logic [3:0] prio;
	} swit_regs_t;

	localparam swit_regs_t RST = '{
		run: 1'b0, runaway: 1'b0, action: 1'b0,
		code: swit_pkg::CODE_RST, stat: swit_pkg::STAT_RST,
		mask: swit_pkg::MASK_RST, restart: 1'b0, irq: 1'b0,
		nmi: 1'b0, wrst: 1'b0, pready: 1'b0, pslverr: 1'b0,
		prdata: 32'h00000000, vec: swit_pkg::VEC_ADDR,
		prio: swit_pkg::PRIO_TOP
	};

	swit_regs_t q, d;
	logic tick;
	logic ovf;
	logic hit;
	logic wr;
	logic interval_mode;
	logic nmi_mode;
	logic rst_mode;
	logic [31:0] rdata;
	swit_pkg::swit_cnt_ctl_t ctl;

	swit_subclk_div #(
		.DIV(SUB_DIV)
	) u_div (
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick)
	);

	assign ctl = '{run: q.run, restart: q.restart, code: q.code};

	swit_counter u_cnt (
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick),
		.ctl(ctl),
		.ovf(ovf)
	);

	always_comb begin
		d = q;
		d.restart = 1'b0;
		d.nmi = 1'b0;
		d.wrst = 1'b0;
		d.pready = 1'b0;
		d.pslverr = 1'b0;
		d.vec = swit_pkg::VEC_ADDR;
		d.prio = swit_pkg::PRIO_TOP;
		interval_mode = !q.runaway && q.action;
		nmi_mode = q.runaway && !q.action;
		rst_mode = q.runaway && q.action;
		hit = 1'b1;
		rdata = 32'h00000000;
		unique case (paddr)
			swit_pkg::swit_byte_addr(swit_pkg::MODE_IDX): begin
				rdata[swit_pkg::RUN_BIT] = q.run;
				rdata[swit_pkg::RUNAWAY_BIT] = q.runaway;
				rdata[swit_pkg::ACTION_BIT] = q.action;
			end
			swit_pkg::swit_byte_addr(swit_pkg::SEL_IDX): begin
				rdata[swit_pkg::CODE_LSB +: 3] = q.code;
			end
			swit_pkg::swit_byte_addr(swit_pkg::STAT_IDX): begin
				rdata[1:0] = q.stat;
			end
			swit_pkg::swit_byte_addr(swit_pkg::MASK_IDX): begin
				rdata[1:0] = q.mask;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
		// Zero-wait slave: the answer is registered in the setup cycle.
		if (psel && !penable) begin
			d.pready = 1'b1;
			d.pslverr = !hit;
			if (!pwrite) begin
				d.prdata = rdata;
			end
		end
		wr = psel && penable && q.pready && pwrite && !q.pslverr;
		if (wr) begin
			unique case (paddr)
				swit_pkg::swit_byte_addr(swit_pkg::MODE_IDX): begin
					// Run and mode bits only ever set by software; reset alone clears them.
					d.run = q.run | pwdata[swit_pkg::RUN_BIT];
					d.restart = pwdata[swit_pkg::RUN_BIT];
					d.runaway = q.runaway | pwdata[swit_pkg::RUNAWAY_BIT];
					d.action = q.action | pwdata[swit_pkg::ACTION_BIT];
				end
				swit_pkg::swit_byte_addr(swit_pkg::SEL_IDX): begin
					d.code = pwdata[swit_pkg::CODE_LSB +: 3];
				end
				swit_pkg::swit_byte_addr(swit_pkg::STAT_IDX): begin
					d.stat = q.stat & ~pwdata[1:0];
				end
				swit_pkg::swit_byte_addr(swit_pkg::MASK_IDX): begin
					d.mask = pwdata[1:0];
				end
				default: begin
					d.mask = q.mask;
				end
			endcase
		end
		// Events are applied after the clear, so a coincident event survives.
		if (ovf && interval_mode) begin
			d.stat[swit_pkg::STAT_INTERVAL_BIT] = 1'b1;
		end
		if (ovf && nmi_mode) begin
			d.stat[swit_pkg::STAT_WATCHDOG_BIT] = 1'b1;
			d.nmi = 1'b1;
		end
		if (ovf && rst_mode) begin
			d.wrst = 1'b1;
		end
		// A stale interval flag turns into a non-maskable interrupt on entry.
		if (!q.runaway && d.runaway && !d.action &&
			q.stat[swit_pkg::STAT_INTERVAL_BIT]) begin
			d.nmi = 1'b1;
		end
		d.irq = |(d.stat & ~d.mask);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= RST;
		end else begin
			q <= d;
		end
	end

	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign overflow_irq = q.irq;
	assign nmi = q.nmi;
	assign sys_reset_req = q.wrst;
	assign irq_vector = q.vec;
	assign irq_priority = q.prio;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	mode_sticky_a: assert property (
		q.run && q.runaway |=> q.run && q.runaway)
		else $error("run or runaway bit cleared");
	action_sticky_a: assert property (q.action |=> q.action)
		else $error("action bit cleared");
	no_interval_a: assert property (q.runaway |-> !interval_mode)
		else $error("interval mode after runaway");
	nmi_fire_a: assert property (
		ovf && nmi_mode |=> nmi && !sys_reset_req)
		else $error("watchdog overflow gave no interrupt");
	reset_fire_a: assert property (
		ovf && rst_mode |=> sys_reset_req && !nmi)
		else $error("watchdog overflow gave no reset request");
	interval_flag_a: assert property (
		ovf && interval_mode |=> q.stat[swit_pkg::STAT_INTERVAL_BIT])
		else $error("interval overflow not flagged");
	// The level follows the registered mask, so a full mask silences it now.
	irq_mask_a: assert property (
		q.mask == 2'h3 |-> !overflow_irq)
		else $error("masked interrupt raised");
	restart_pulse_a: assert property (
		wr && paddr == swit_pkg::swit_byte_addr(swit_pkg::MODE_IDX) &&
		pwdata[swit_pkg::RUN_BIT] |=> q.restart && q.run)
		else $error("restart write did not start counter");
	vector_a: assert property (
		irq_vector == 16'h0004 && irq_priority == 4'h0)
		else $error("vector or priority wrong");
	interval_irq_c: cover property (ovf && interval_mode ##1 overflow_irq);
	nmi_c: cover property (ovf && nmi_mode);
	reset_c: cover property (ovf && rst_mode);
endmodule
`default_nettype wire

// file: shared/swit_pkg.sv
// Package of constants, types and helpers for the subclock watchdog timer.
// Function
// - Runaway mode bit set makes the block a runaway detector.
// - Code picks 2^12..2^18 subclock periods, code 111 picks 2^20.
// - Writing one to the restart bit starts counting in the chosen mode.
// - Each restart write while running clears the count and counts again.
// - Overflow gives a reset or a non-maskable interrupt per action bit.
// - Mode 10 raises a non-maskable interrupt; mode 11 requests reset.
// - Restart leaves the 8-bit prescaler alone; periods may be 2^8 short.
// - Mode 01 is an interval timer interrupting once per period.
// - In interval mode counting begins only after the restart bit is set.
// - Interval overflow interrupt is maskable by its own mask flag.
// - Interval overflow interrupt has the top maskable priority.
// - Once runaway mode is set, interval mode cannot return until reset.
// - The first interval after a mode write may be up to 2^8 shorter.
// - The counter runs from a 32.768 kHz or 38.4 kHz subsystem clock; here SUBCLK_HZ sets 32.768 kHz only.
// - Software cannot clear the restart bit; only reset stops the counter.
// - Software cannot clear either mode select bit once set.
package swit_pkg;
	localparam int CLK_HZ = 20000000;
	localparam int SUBCLK_HZ = 32768;
	localparam int SUB_DIV = CLK_HZ / SUBCLK_HZ;
	localparam int PRE_W = 8;
	localparam int UP_W = 12;
	localparam int ADDR_W = 18;
	localparam logic [15:0] MODE_IDX = 16'hFF49;
	localparam logic [15:0] SEL_IDX = 16'hFF4A;
	localparam logic [15:0] STAT_IDX = 16'hFF4B;
	localparam logic [15:0] MASK_IDX = 16'hFF4C;
	localparam int RUN_BIT = 7;
	localparam int RUNAWAY_BIT = 4;
	localparam int ACTION_BIT = 3;
	localparam int CODE_LSB = 0;
	localparam int STAT_INTERVAL_BIT = 0;
	localparam int STAT_WATCHDOG_BIT = 1;
	localparam logic [2:0] CODE_RST = 3'h0;
	localparam logic [1:0] STAT_RST = 2'h0;
	localparam logic [1:0] MASK_RST = 2'h3;
	localparam logic [15:0] VEC_ADDR = 16'h0004;
	localparam logic [3:0] PRIO_TOP = 4'h0;

	typedef struct packed {
		logic run;
		logic restart;
		logic [2:0] code;
	} swit_cnt_ctl_t;

	function automatic logic [ADDR_W-1:0] swit_byte_addr(input logic [15:0] idx);
		swit_byte_addr = {idx, 2'h0};
	endfunction

	// Bits of the upper stage that must all be ones at the overflow point.
	function automatic logic [UP_W-1:0] swit_span_mask(input logic [2:0] code);
		unique case (code)
			3'h0: swit_span_mask = 12'h00F;
			3'h1: swit_span_mask = 12'h01F;
			3'h2: swit_span_mask = 12'h03F;
			3'h3: swit_span_mask = 12'h07F;
			3'h4: swit_span_mask = 12'h0FF;
			3'h5: swit_span_mask = 12'h1FF;
			3'h6: swit_span_mask = 12'h3FF;
			3'h7: swit_span_mask = 12'hFFF;
		endcase
	endfunction
endpackage

// file: rtl/swit_subclk_div.sv
// Divider that makes the subsystem clock tick as an enable pulse.
`timescale 1ns/100ps
`default_nettype none
module swit_subclk_div #(
	parameter int DIV = swit_pkg::SUB_DIV
) (
	input wire logic pclk,
	input wire logic presetn,
	output logic tick
);
	typedef struct packed {
		logic [15:0] cnt;
		logic tick;
	} swit_div_t;

	swit_div_t q, d;

	// The 20 MHz clock is no whole multiple of the subclock,
	// so the rate is close, not exact.
	always_comb begin
		d = q;
		d.tick = 1'b0;
		if (q.cnt == 16'(DIV - 1)) begin
			d.cnt = 16'h0000;
			d.tick = 1'b1;
		end else begin
			d.cnt = q.cnt + 16'h0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign tick = q.tick;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	tick_spacing_a: assert property (tick |=> !tick || (DIV == 1))
		else $error("subclock tick repeated too soon");
endmodule
`default_nettype wire

// file: rtl/swit_counter.sv
// Prescaler and upper counter stage with overflow detection.
`timescale 1ns/100ps
`default_nettype none
module swit_counter (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic tick,
	input wire swit_pkg::swit_cnt_ctl_t ctl,
	output logic ovf
);
	typedef struct packed {
		logic [swit_pkg::PRE_W-1:0] pre;
		logic [swit_pkg::UP_W-1:0] up;
		logic ovf;
	} swit_cnt_t;

	swit_cnt_t q, d;
	logic carry;
	logic [swit_pkg::UP_W-1:0] span;

	always_comb begin
		d = q;
		d.ovf = 1'b0;
		carry = tick && (q.pre == '1);
		span = swit_pkg::swit_span_mask(ctl.code);
		if (tick) begin
			d.pre = q.pre + 1'b1;
		end
		if (carry && ctl.run) begin
			d.up = q.up + 1'b1;
			d.ovf = ((q.up & span) == span);
		end
		// The prescaler keeps running, so the first period may be short.
		if (ctl.restart) begin
			d.up = '0;
			d.ovf = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign ovf = q.ovf;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	restart_clear_a: assert property (ctl.restart |=> q.up == '0)
		else $error("restart did not clear upper stage");
	prescale_free_a: assert property (
		ctl.restart && q.pre != '1 |=> q.pre >= $past(q.pre))
		else $error("prescaler disturbed by restart");
	ovf_run_a: assert property (ovf |-> ctl.run)
		else $error("overflow without run");
	ovf_tap_a: assert property (
		ovf |-> (q.up & swit_pkg::swit_span_mask(ctl.code)) == '0)
		else $error("overflow at wrong tap");
endmodule
`default_nettype wire

// file: sim/swit_irq_partner.sv
// Model of the interrupt controller and reset logic facing the timer.
`timescale 1ns/100ps
`default_nettype none
module swit_irq_partner (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic overflow_irq,
	input wire logic nmi,
	input wire logic sys_reset_req,
	input wire logic [15:0] irq_vector,
	input wire logic [3:0] irq_priority,
	output logic [7:0] nmi_cnt,
	output logic [7:0] rst_cnt,
	output logic [15:0] vec_seen,
	output logic [3:0] prio_seen
);
	// Every cycle nmi or sys_reset_req is high is counted, so a stuck request shows as a growing count.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nmi_cnt <= 8'h00;
			rst_cnt <= 8'h00;
			vec_seen <= 16'hFFFF;
			prio_seen <= 4'hF;
		end else begin
			if (nmi) begin
				nmi_cnt <= nmi_cnt + 8'h01;
				vec_seen <= irq_vector;
			end
			if (sys_reset_req) begin
				rst_cnt <= rst_cnt + 8'h01;
			end
			if (overflow_irq) begin
				prio_seen <= irq_priority;
			end
		end
	end
endmodule
`default_nettype wire

// file: sim/tb_subclock_watchdog_interval_timer.sv
// Self-checking bench for the subclock watchdog and interval timer.
`timescale 1ns/100ps
`default_nettype none
module tb_subclock_watchdog_interval_timer;
	localparam logic [17:0] A_MODE = {swit_pkg::MODE_IDX, 2'h0};
	localparam logic [17:0] A_SEL = {swit_pkg::SEL_IDX, 2'h0};
	localparam logic [17:0] A_STAT = {swit_pkg::STAT_IDX, 2'h0};
	localparam logic [17:0] A_MASK = {swit_pkg::MASK_IDX, 2'h0};
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic overflow_irq, nmi, sys_reset_req;
	logic [17:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] irq_vector, vec_seen;
	logic [3:0] irq_priority, prio_seen;
	logic [7:0] nmi_cnt, rst_cnt;
	logic err;
	int errors, n_tests, t0, t, i, c;
	int cyc = 0;
	swit_top #(.SUB_DIV(1)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .overflow_irq(overflow_irq), .nmi(nmi),
		.sys_reset_req(sys_reset_req), .irq_vector(irq_vector),
		.irq_priority(irq_priority));
	swit_irq_partner partner (.pclk(pclk), .presetn(presetn),
		.overflow_irq(overflow_irq), .nmi(nmi),
		.sys_reset_req(sys_reset_req), .irq_vector(irq_vector),
		.irq_priority(irq_priority), .nmi_cnt(nmi_cnt), .rst_cnt(rst_cnt),
		.vec_seen(vec_seen), .prio_seen(prio_seen));
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	always @(posedge pclk) cyc <= cyc + 1;
	task results;
		$display("errors %0d n_tests %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			errors++;
		end
	endtask
	task chk_rng(input string nm, input int lo, input int hi, input int g);
		n_tests++;
		if (g < lo || g > hi) begin
			$display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, g);
			errors++;
		end
	endtask
	// The answer is taken at the rising edge that samples pready high.
	task apb(input logic w, input logic [17:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [17:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rdc(input string nm, input logic [17:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h00000000);
		chk(nm, e, rd);
	endtask
	task do_reset;
		presetn <= 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
	endtask
	task wait_irq(output int tt);
		@(negedge pclk);
		for (int k = 0; k < 20000 && overflow_irq !== 1'b1; k++) begin
			@(negedge pclk);
		end
		tt = cyc;
	endtask
	initial begin
		repeat (90000) @(posedge pclk);
		errors++;
		results();
	end
	initial begin
		{presetn, psel, penable, pwrite} = 4'h0;
		paddr = 18'h00000;
		pwdata = 32'h00000000;
		{errors, n_tests} = 0;
		do_reset();
		rdc("mode rst", A_MODE, 32'h00000000);
		rdc("sel rst", A_SEL, 32'h00000000);
		rdc("stat rst", A_STAT, 32'h00000000);
		rdc("mask rst", A_MASK, 32'h00000003);
		rdc("unmapped", 18'h00100, 32'h00000000);
		chk("unmapped err", 1, err);
		chk("vector", 16'h0004, irq_vector);
		wr(A_MASK, 32'h00000000);
		for (c = 0; c < 3; c++) begin
			wr(A_SEL, c);
			wr(A_MODE, 32'h00000088);
			t0 = cyc;
			wait_irq(t);
			chk_rng("first period", (1 << (12 + c)) - 256,
				(1 << (12 + c)) + 4, t - t0);
			wr(A_STAT, 32'h00000001);
			repeat (2) @(negedge pclk);
			chk("irq cleared", 0, overflow_irq);
		end
		wait_irq(t0);
		chk("steady period", 16384, t0 - t);
		chk("priority", 4'h0, prio_seen);
		wr(A_SEL, 32'h00000000);
		wr(A_MASK, 32'h00000001);
		wr(A_MODE, 32'h00000088);
		wr(A_STAT, 32'h00000001);
		repeat (4400) @(posedge pclk);
		rdc("masked stat", A_STAT, 32'h00000001);
		chk("masked irq", 0, overflow_irq);
		wr(A_MASK, 32'h00000000);
		repeat (3) @(negedge pclk);
		chk("unmasked irq", 1, overflow_irq);
		wr(A_MODE, 32'h00000088);
		wr(A_STAT, 32'h00000001);
		for (i = 0; i < 3; i++) begin
			repeat (2000) @(posedge pclk);
			wr(A_MODE, 32'h00000088);
		end
		rdc("no ovf restart", A_STAT, 32'h00000000);
		wr(A_MODE, 32'h00000000);
		rdc("mode sticky", A_MODE, 32'h00000088);
		do_reset();
		wr(A_MODE, 32'h00000090);
		for (i = 0; i < 3; i++) begin
			repeat (3000) @(posedge pclk);
			wr(A_MODE, 32'h00000090);
		end
		chk("no nmi serviced", 0, nmi_cnt);
		for (i = 0; i < 4400 && nmi_cnt == 0; i++) @(posedge pclk);
		chk("nmi count", 1, nmi_cnt);
		chk("nmi vector", 16'h0004, vec_seen);
		chk("no reset", 0, rst_cnt);
		rdc("nmi stat", A_STAT, 32'h00000002);
		wr(A_MODE, 32'h00000008);
		rdc("runaway kept", A_MODE, 32'h00000098);
		for (i = 0; i < 4400 && rst_cnt == 0; i++) @(posedge pclk);
		chk("reset count", 1, rst_cnt);
		results();
	end
endmodule
`default_nettype wire
